// File: verilog/pfc_ctrl.sv
// performance counter control: wishbone registers, coherent reads, inhibits
// Contract
// - reading a low byte first freezes the high byte for the next read.
// - with select bit 0 counters saturate and stop at maximum.
// - in saturating mode a low byte read cycle clears the counter read.
// - in saturating mode events during the read are kept and added after.
// - with select bit 1 counters wrap to zero and keep counting.
// - in roll-over mode reads never clear a counter.
// - writing 1 to global reset clears all counters; the bit self clears.
// - zero to low byte then zero to high byte next clears that counter.
// - non-framing counters stop while any alarm is active.
// - tracking pin low uses path start loss; high uses pointer loss or AIS.
// - drop clock loss always inhibits counting.
// - alarm enable 0 uses overhead AIS; 1 uses external status/AIS pins.
// - with overhead processing, enabled trace lock loss or mismatch inhibit.
// - low level on external AIS input inhibits counting.
// - label check enabled: label mismatch or all-zero label inhibits.
// - framing error counters are inhibited only on loss of frame alignment.
module pfc_ctrl
    import pfc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    // events to count, one-cycle pulses
    input  wire logic [PFC_NUM_CNT-1:0] event_i,
    // alarms
    input  wire logic                   pointer_tracking_pin_i,
    input  wire logic                   drop_path_start_pulse_lost_i,
    input  wire logic                   rx_pointer_lost_i,
    input  wire logic                   rx_path_ais_alarm_i,
    input  wire logic                   drop_clock_lost_i,
    input  wire logic                   orderwire_byte_ais_i,
    input  wire logic                   ext_status_pin_alarm_i,
    input  wire logic                   ext_path_ais_pin_alarm_i,
    input  wire logic                   path_overhead_processing_pin_i,
    input  wire logic                   trace_lock_lost_i,
    input  wire logic                   trace_id_mismatch_i,
    input  wire logic                   ext_ais_input_n_i,
    input  wire logic                   signal_label_mismatch_i,
    input  wire logic                   signal_label_all_zero_i,
    input  wire logic                   frame_align_lost_i,
    // inhibit status
    output logic                        counting_inhibit_o,
    output logic                        framing_inhibit_o
);
    typedef struct packed {
        logic                 saturate_roll_select;
        logic                 external_alarm_enable;
        logic                 trace_lock_check_enable;
        logic                 trace_mismatch_check_enable;
        logic                 signal_label_check_enable;
        logic                 global_counter_reset;
        logic                 ack;
        logic [31:0]          dat;
        logic                 frz_vld;
        logic [PFC_IDX_W-1:0] frz_idx;
        logic [7:0]           frz_hi;
        logic                 zl_vld;
        logic [PFC_IDX_W-1:0] zl_idx;
        logic                 inh_gen;
        logic                 inh_frm;
    } pfc_state_type;

    pfc_state_type                       st_r;
    pfc_state_type                       st_nxt;
    logic [PFC_NUM_CNT-1:0][PFC_WIDE_W-1:0] cnt_v;
    logic [PFC_NUM_CNT-1:0]              read_clr;
    logic [PFC_NUM_CNT-1:0]              wr_clr;
    logic [PFC_NUM_CNT-1:0]              cnt_clr;
    logic                                inh_gen;
    logic                                req;
    logic [5:0]                          idx;
    logic [5:0]                          cnt_off;
    logic                                is_cnt;
    logic                                is_hi;
    logic                                is_wide;
    logic [PFC_IDX_W-1:0]                k;
    logic                                wr_zero;

    assign wb_dat_o           = st_r.dat;
    assign wb_ack_o           = st_r.ack;
    assign counting_inhibit_o = st_r.inh_gen;
    assign framing_inhibit_o  = st_r.inh_frm;

    // any one alarm holds off all non-framing counters
    assign inh_gen =
        (pointer_tracking_pin_i ? (rx_pointer_lost_i | rx_path_ais_alarm_i)
                                : drop_path_start_pulse_lost_i)
        | drop_clock_lost_i
        | (st_r.external_alarm_enable
            ? (ext_status_pin_alarm_i | ext_path_ais_pin_alarm_i)
            : orderwire_byte_ais_i)
        | (path_overhead_processing_pin_i
            & ((st_r.trace_lock_check_enable & trace_lock_lost_i)
             | (st_r.trace_mismatch_check_enable
                & trace_id_mismatch_i)))
        | ~ext_ais_input_n_i
        | (st_r.signal_label_check_enable
            & (signal_label_mismatch_i | signal_label_all_zero_i));

    assign req     = wb_cyc_i & wb_stb_i & ~st_r.ack;
    assign idx     = wb_adr_i[7:2];
    assign cnt_off = idx - PFC_CNT_IDX;
    assign is_cnt  = (idx >= PFC_CNT_IDX) && (cnt_off < PFC_CNT_SPAN);
    assign is_hi   = cnt_off[0];
    assign k       = cnt_off[PFC_IDX_W:1];
    assign is_wide = (int'(k) < PFC_NUM_WIDE);
    assign wr_zero = (wb_dat_i[7:0] == PFC_ZERO_BYTE);

    always_comb begin
        st_nxt                      = st_r;
        read_clr                    = '0;
        wr_clr                      = '0;
        st_nxt.ack                  = 1'b0;
        st_nxt.global_counter_reset = 1'b0;
        st_nxt.inh_gen              = inh_gen;
        st_nxt.inh_frm              = frame_align_lost_i;
        if (req) begin
            st_nxt.ack = 1'b1;
            st_nxt.dat = PFC_ZERO_WORD;
            if (wb_we_i) begin
                // any other write breaks a pending zero-write pair
                st_nxt.zl_vld = 1'b0;
                if (wb_sel_i[0] && idx == PFC_CTRL_IDX) begin
                    st_nxt.saturate_roll_select =
                        wb_dat_i[PFC_CTRL_ROLL];
                    st_nxt.external_alarm_enable =
                        wb_dat_i[PFC_CTRL_EXTA];
                    st_nxt.trace_lock_check_enable =
                        wb_dat_i[PFC_CTRL_LOCK];
                    st_nxt.trace_mismatch_check_enable =
                        wb_dat_i[PFC_CTRL_TIM];
                    st_nxt.signal_label_check_enable =
                        wb_dat_i[PFC_CTRL_PSL];
                    st_nxt.global_counter_reset =
                        wb_dat_i[PFC_CTRL_GRST];
                end else if (wb_sel_i[0] && is_cnt && wr_zero) begin
                    if (!is_hi && is_wide) begin
                        st_nxt.zl_vld = 1'b1;
                        st_nxt.zl_idx = k;
                    end else if (!is_hi) begin
                        // an 8-bit counter has no high byte to pair with
                        wr_clr[k] = 1'b1;
                    end else if (st_r.zl_vld && st_r.zl_idx == k) begin
                        wr_clr[k] = 1'b1;
                    end
                end
            end else if (idx == PFC_CTRL_IDX) begin
                st_nxt.dat[PFC_CTRL_ROLL] = st_r.saturate_roll_select;
                st_nxt.dat[PFC_CTRL_EXTA] = st_r.external_alarm_enable;
                st_nxt.dat[PFC_CTRL_LOCK] = st_r.trace_lock_check_enable;
                st_nxt.dat[PFC_CTRL_TIM]  =
                    st_r.trace_mismatch_check_enable;
                st_nxt.dat[PFC_CTRL_PSL]  = st_r.signal_label_check_enable;
                st_nxt.dat[PFC_CTRL_GRST] = st_r.global_counter_reset;
            end else if (idx == PFC_STAT_IDX) begin
                st_nxt.dat[PFC_STAT_INH] = st_r.inh_gen;
                st_nxt.dat[PFC_STAT_FRM] = st_r.inh_frm;
            end else if (is_cnt && !is_hi) begin
                st_nxt.dat[7:0] = cnt_v[k][7:0];
                if (is_wide) begin
                    st_nxt.frz_vld = 1'b1;
                    st_nxt.frz_idx = k;
                    st_nxt.frz_hi  = cnt_v[k][15:8];
                end
                // a roll-over counter keeps accumulating across reads
                read_clr[k] = ~st_r.saturate_roll_select;
            end else if (is_cnt && is_wide) begin
                st_nxt.dat[7:0] = (st_r.frz_vld && st_r.frz_idx == k)
                                  ? st_r.frz_hi : cnt_v[k][15:8];
                st_nxt.frz_vld  = 1'b0;
            end
        end
    end

    assign cnt_clr = wr_clr | {PFC_NUM_CNT{st_r.global_counter_reset}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.saturate_roll_select        <= 1'b0;
            st_r.external_alarm_enable       <= 1'b0;
            st_r.trace_lock_check_enable     <= 1'b0;
            st_r.trace_mismatch_check_enable <= 1'b0;
            st_r.signal_label_check_enable   <= 1'b0;
            st_r.global_counter_reset        <= 1'b0;
            st_r.ack                         <= 1'b0;
            st_r.dat                         <= PFC_ZERO_WORD;
            st_r.frz_vld                     <= 1'b0;
            st_r.frz_idx                     <= '0;
            st_r.frz_hi                      <= PFC_ZERO_BYTE;
            st_r.zl_vld                      <= 1'b0;
            st_r.zl_idx                      <= '0;
            st_r.inh_gen                     <= 1'b0;
            st_r.inh_frm                     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    for (genvar g = 0; g < PFC_NUM_CNT; g++) begin : g_cnt
        localparam int W = (g < PFC_NUM_WIDE) ? PFC_WIDE_W : PFC_NARROW_W;
        localparam bit FRM = (g == PFC_RX_FRM_CNT) || (g == PFC_TX_FRM_CNT);
        logic [W-1:0] value;
        logic         inh;

        // framing error counters ignore the alarm list
        assign inh = FRM ? frame_align_lost_i : inh_gen;

        pfc_counter #(
            .WIDTH      (W)
        ) u_cnt (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .event_i    (event_i[g]),
            .inhibit_i  (inh),
            .roll_i     (st_r.saturate_roll_select),
            .clear_i    (cnt_clr[g]),
            .read_clr_i (read_clr[g]),
            .count_o    (value)
        );
        assign cnt_v[g] = PFC_WIDE_W'(value);
    end

    AST_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && is_cnt && !is_hi && is_wide
        |=> st_r.frz_vld && st_r.frz_hi == $past(cnt_v[k][15:8]))
        else $error("high byte not frozen by low byte read");
    AST_ROLL_NO_CLEAR: assert property (@(posedge clk_i)
        disable iff (rst_i)
        st_r.saturate_roll_select |-> read_clr == '0)
        else $error("roll-over read cleared a counter");
    AST_GRST_SELF_CLEAR: assert property (@(posedge clk_i)
        disable iff (rst_i)
        st_r.global_counter_reset |=> !st_r.global_counter_reset)
        else $error("global reset bit did not clear itself");
    AST_PAIR_CLEAR: assert property (@(posedge clk_i)
        disable iff (rst_i)
        req && wb_we_i && wb_sel_i[0] && is_cnt && is_hi && wr_zero
        && st_r.zl_vld && st_r.zl_idx == k |-> wr_clr[k])
        else $error("zero pair write did not clear the counter");
    AST_TRACK_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
        pointer_tracking_pin_i && rx_pointer_lost_i |=> st_r.inh_gen)
        else $error("pointer loss did not inhibit counting");
    AST_CLOCK_LOSS: assert property (@(posedge clk_i)
        disable iff (rst_i)
        drop_clock_lost_i [*2] |-> st_r.inh_gen)
        else $error("drop clock loss did not inhibit counting");
    AST_EXT_AIS: assert property (@(posedge clk_i) disable iff (rst_i)
        !ext_ais_input_n_i |=> st_r.inh_gen)
        else $error("external AIS did not inhibit counting");
    AST_FRAMING: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> st_r.inh_frm == $past(frame_align_lost_i))
        else $error("framing inhibit does not follow frame loss");
    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r.ack |=> !st_r.ack)
        else $error("ack held longer than one cycle");

    COV_COHERENT: cover property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && is_cnt && is_hi && st_r.frz_vld);
    COV_PAIR_CLEAR: cover property (@(posedge clk_i) disable iff (rst_i)
        |wr_clr);
    COV_GRST: cover property (@(posedge clk_i) disable iff (rst_i)
        st_r.global_counter_reset);
    COV_INHIBIT: cover property (@(posedge clk_i) disable iff (rst_i)
        st_r.inh_gen ##1 !st_r.inh_gen);
endmodule

// File: verilog/pfc_pkg.sv
// constants shared by the performance counter control block
package pfc_pkg;
    // counter set: the first PFC_NUM_WIDE counters are 16 bit, the rest 8 bit
    localparam int PFC_NUM_CNT    = 4;
    localparam int PFC_NUM_WIDE   = 3;
    localparam int PFC_WIDE_W     = 16;
    localparam int PFC_NARROW_W   = 8;
    localparam int PFC_IDX_W      = 2;
    localparam int PFC_RX_FRM_CNT = 0;
    localparam int PFC_TX_FRM_CNT = 1;

    // word indices on the bus (byte address = 4 * index)
    localparam logic [5:0] PFC_CTRL_IDX  = 6'h00;
    localparam logic [5:0] PFC_STAT_IDX  = 6'h01;
    localparam logic [5:0] PFC_CNT_IDX   = 6'h04;
    localparam logic [5:0] PFC_CNT_SPAN  = 6'h08;

    // control register fields
    localparam int PFC_CTRL_ROLL = 0;
    localparam int PFC_CTRL_EXTA = 1;
    localparam int PFC_CTRL_LOCK = 2;
    localparam int PFC_CTRL_TIM  = 3;
    localparam int PFC_CTRL_PSL  = 4;
    localparam int PFC_CTRL_GRST = 7;

    // status register fields
    localparam int PFC_STAT_INH  = 0;
    localparam int PFC_STAT_FRM  = 1;

    localparam logic [7:0]  PFC_ZERO_BYTE = 8'h00;
    localparam logic [31:0] PFC_ZERO_WORD = 32'h0000_0000;
endpackage

// File: verilog/pfc_counter.sv
// one performance counter with saturate/roll, read clear and hold of events
module pfc_counter
    import pfc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // counting
    input  wire logic             event_i,
    input  wire logic             inhibit_i,
    input  wire logic             roll_i,
    // clearing
    input  wire logic             clear_i,
    input  wire logic             read_clr_i,
    // value
    output logic [WIDTH-1:0]      count_o
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } pfc_cnt_state_type;

    localparam logic [WIDTH-1:0] CNT_MAX = '1;
    localparam logic [WIDTH-1:0] CNT_ONE = WIDTH'(1);

    pfc_cnt_state_type st_r;
    pfc_cnt_state_type st_nxt;
    logic              inc;

    assign inc     = event_i & ~inhibit_i;
    assign count_o = st_r.cnt;

    always_comb begin
        st_nxt = st_r;
        if (clear_i) begin
            st_nxt.cnt = '0;
        end else if (read_clr_i) begin
            // an event in the read cycle is kept, not lost to the clear
            st_nxt.cnt = inc ? CNT_ONE : '0;
        end else if (inc) begin
            if (st_r.cnt == CNT_MAX && !roll_i) begin
                st_nxt.cnt = st_r.cnt;
            end else begin
                st_nxt.cnt = st_r.cnt + CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.cnt <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    AST_SATURATE: assert property (@(posedge clk_i) disable iff (rst_i)
        !roll_i && st_r.cnt == CNT_MAX && !clear_i && !read_clr_i
        |=> st_r.cnt == CNT_MAX)
        else $error("saturating counter left its maximum");
    AST_READ_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        read_clr_i && !clear_i && !inc |=> st_r.cnt == '0)
        else $error("read cycle did not clear the counter");
    AST_READ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        read_clr_i && !clear_i && inc |=> st_r.cnt == CNT_ONE)
        else $error("event during read cycle was lost");
    AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        roll_i && inc && st_r.cnt == CNT_MAX && !clear_i && !read_clr_i
        |=> st_r.cnt == '0)
        else $error("roll-over counter did not wrap to zero");
    AST_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        clear_i |=> st_r.cnt == '0)
        else $error("counter not cleared");
    AST_INHIBIT: assert property (@(posedge clk_i) disable iff (rst_i)
        inhibit_i && !clear_i && !read_clr_i |=> $stable(st_r.cnt))
        else $error("inhibited counter moved");
    AST_RESET: assert property (@(posedge clk_i)
        rst_i |=> st_r.cnt == '0)
        else $error("counter not zero after reset");
endmodule

// File: testbench/pfc_cpu_model.sv
// processor model: one wishbone classic cycle per request of the bench
module pfc_cpu_model
    import pfc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // requests from the bench
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [7:0]  dat_i,
    output logic             done_o   = 1'b0,
    output logic [7:0]       rdata_o  = 8'h00,
    // wishbone master
    output logic             wb_cyc_o = 1'b0,
    output logic             wb_stb_o = 1'b0,
    output logic             wb_we_o  = 1'b0,
    output logic [7:0]       wb_adr_o = 8'h00,
    output logic [3:0]       wb_sel_o = 4'h0,
    output logic [31:0]      wb_dat_o = PFC_ZERO_WORD,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ack_i
);
    timeunit 1ns;
    timeprecision 1ns;

    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            wb_cyc_o <= 1'b0;
            wb_stb_o <= 1'b0;
        end else if (wb_cyc_o && wb_ack_i) begin
            rdata_o  <= wb_dat_i[7:0];
            done_o   <= 1'b1;
            wb_cyc_o <= 1'b0;
            wb_stb_o <= 1'b0;
            // released lines change, so a stale request cannot look valid
            wb_adr_o <= ~wb_adr_o;
            wb_dat_o <= ~wb_dat_o;
        end else if (req_i && !wb_cyc_o) begin
            // requests leave strictly in bench order: low before high byte
            wb_cyc_o <= 1'b1;
            wb_stb_o <= 1'b1;
            wb_we_o  <= we_i;
            wb_adr_o <= adr_i;
            wb_sel_o <= 4'h1;
            wb_dat_o <= {24'h00_0000, dat_i};
        end
    end
endmodule

// File: testbench/test_performance_counter_control.sv
// self-checking bench for the performance counter control block
module test_performance_counter_control
    import pfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        req  = 1'b0;
    logic        we   = 1'b0;
    logic [7:0]  adr  = 8'h00;
    logic [7:0]  wdat = 8'h00;
    logic [3:0]  ev   = 4'h0;
    logic [14:0] alm  = 15'h0800;
    logic        done, cyc, stb, wbwe, ack, cnt_inh, frm_inh;
    logic [7:0]  rdata, wadr;
    logic [3:0]  sel;
    logic [31:0] mdat, sdat;
    logic [7:0]  expq [$];
    int          errors = 0;
    int          check_count = 0;
    int          seed = 32'ha1c1;
    int          n;
    // ctrl, expected {frame, alarm} inhibit, alarm inputs
    logic [31:0] tbl [22] = '{
        32'h0001_0802, 32'h0000_0803, 32'h0001_0805, 32'h0000_0804,
        32'h0001_0809, 32'h0001_0810, 32'h0001_0811, 32'h0001_0820,
        32'h0200_0820, 32'h0201_0840, 32'h0000_0840, 32'h0201_0880,
        32'h0401_0b00, 32'h0000_0b00, 32'h0400_0a00, 32'h0801_0d00,
        32'h0000_0d00, 32'h0001_0000, 32'h1001_1800, 32'h0000_1800,
        32'h1001_2800, 32'h0002_4800};

    pfc_cpu_model cpu_u (.clk_i(clk), .rst_i(rst), .req_i(req), .we_i(we),
        .adr_i(adr), .dat_i(wdat), .done_o(done), .rdata_o(rdata),
        .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(wbwe), .wb_adr_o(wadr),
        .wb_sel_o(sel), .wb_dat_o(mdat), .wb_dat_i(sdat), .wb_ack_i(ack));

    pfc_ctrl dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(wbwe), .wb_adr_i(wadr), .wb_sel_i(sel), .wb_dat_i(mdat),
        .wb_dat_o(sdat), .wb_ack_o(ack), .event_i(ev),
        .pointer_tracking_pin_i(alm[0]),
        .drop_path_start_pulse_lost_i(alm[1]), .rx_pointer_lost_i(alm[2]),
        .rx_path_ais_alarm_i(alm[3]), .drop_clock_lost_i(alm[4]),
        .orderwire_byte_ais_i(alm[5]), .ext_status_pin_alarm_i(alm[6]),
        .ext_path_ais_pin_alarm_i(alm[7]),
        .path_overhead_processing_pin_i(alm[8]), .trace_lock_lost_i(alm[9]),
        .trace_id_mismatch_i(alm[10]), .ext_ais_input_n_i(alm[11]),
        .signal_label_mismatch_i(alm[12]), .signal_label_all_zero_i(alm[13]),
        .frame_align_lost_i(alm[14]), .counting_inhibit_o(cnt_inh),
        .framing_inhibit_o(frm_inh));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic cmp_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp,
                           input logic got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic final_report();
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one bus transfer through the processor model, bounded wait
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int k;
        @(posedge clk);
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        @(posedge clk);
        req <= 1'b0;
        k = 0;
        // return on a rising edge so that later stimulus stays edge aligned
        while (done !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k >= 50) begin
            errors++;
            final_report();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask

    task automatic pulse(input logic [3:0] mask, input int cnt);
        @(posedge clk);
        ev <= mask;
        repeat (cnt) @(posedge clk);
        ev <= 4'h0;
    endtask

    // read results are matched in issue order
    always @(posedge clk) begin
        if (done === 1'b1 && wbwe === 1'b0) begin
            if (expq.size() == 0) errors++;
            else cmp_byte("read data", expq.pop_front(), rdata);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 8'h00);
        for (int i = 0; i < 4; i++) rd(8'h10 + 8'(8 * i), 8'h00);
        n = 1 + ($unsigned($random(seed)) % 40);
        pulse(4'h4, n);
        rd(8'h20, 8'(n));
        rd(8'h20, 8'h00);
        pulse(4'h8, 300);
        rd(8'h28, 8'hff);
        bus(1'b1, 8'hfc, 8'h5a);
        rd(8'hfc, 8'h00);
        // events during the read land after the clear
        @(posedge clk);
        ev <= 4'h8;
        rd(8'h28, 8'h02);
        ev <= 4'h0;
        // two events after the clear plus the one at the releasing edge
        rd(8'h28, 8'h03);
        bus(1'b1, 8'h00, 8'h01);
        pulse(4'h8, 262);
        rd(8'h28, 8'h06);
        rd(8'h28, 8'h06);
        pulse(4'h4, 261);
        rd(8'h20, 8'h05);
        pulse(4'h4, 255);
        rd(8'h24, 8'h01);
        rd(8'h24, 8'h02);
        bus(1'b1, 8'h20, 8'h00);
        bus(1'b1, 8'h24, 8'h00);
        rd(8'h20, 8'h00);
        rd(8'h24, 8'h00);
        pulse(4'h4, 3);
        bus(1'b1, 8'h20, 8'h00);
        bus(1'b1, 8'h00, 8'h01);
        bus(1'b1, 8'h24, 8'h00);
        rd(8'h20, 8'h03);
        pulse(4'h7, 9);
        bus(1'b1, 8'h00, 8'h81);
        rd(8'h00, 8'h01);
        for (int i = 0; i < 3; i++) rd(8'h10 + 8'(8 * i), 8'h00);
        for (int i = 0; i < 22; i++) begin
            bus(1'b1, 8'h00, tbl[i][31:24]);
            @(posedge clk);
            alm <= tbl[i][14:0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            cmp_bit("alarm inhibit", tbl[i][16], cnt_inh);
            cmp_bit("frame inhibit", tbl[i][17], frm_inh);
            rd(8'h04, tbl[i][23:16]);
        end
        alm <= 15'h0810;
        pulse(4'h5, 3);
        rd(8'h10, 8'h03);
        rd(8'h20, 8'h00);
        alm <= 15'h4800;
        pulse(4'h5, 3);
        rd(8'h10, 8'h00);
        rd(8'h20, 8'h03);
        alm <= 15'h0800;
        repeat (3) @(posedge clk);
        if (expq.size() != 0) errors++;
        final_report();
    end
endmodule
